// ### hdl/repeater_regs_defines.vh
// Register offsets, reset values, field positions and slave constants
`ifndef REPEATER_REGS_DEFINES_VH
`define REPEATER_REGS_DEFINES_VH

// ----------------------------------------------------------------------------
// Register offsets
// ----------------------------------------------------------------------------
`define SLAVE_CONTROL_ADDR 8'h06
`define RESET_AND_CONTROL_ADDR 8'h07
`define PIN_OVERRIDE_SELECT_ADDR 8'h08

// ----------------------------------------------------------------------------
// Reset values
// ----------------------------------------------------------------------------
`define SLAVE_CONTROL_RESET 8'h10
`define RESET_AND_CONTROL_RESET 8'h01
`define PIN_OVERRIDE_SELECT_RESET 8'h00

// ----------------------------------------------------------------------------
// Field positions
// ----------------------------------------------------------------------------
`define EEPROM_CFG_DISABLE_BIT 7
`define REG_CONTROL_ENABLE_BIT 3
`define RESET_REGISTERS_BIT 6
`define RESET_MASTER_BIT 5
`define IDLE_THRESHOLD_OVR_BIT 6
`define IDLE_FORCE_OVR_BIT 4
`define HIGH_RATE_BIT 3

// ----------------------------------------------------------------------------
// Serial slave
// ----------------------------------------------------------------------------
`define BYTE_BITS 4'h8
`define DEFAULT_DEV_ADDR 7'h5a

`endif

// ### hdl/smbus_byte_engine.v
// Serial slave engine: address match, register pointer, byte writes and reads
`timescale 1ns/1ns
`include "repeater_regs_defines.vh"

module smbus_byte_engine #(
    parameter [6:0] DEV_ADDR = `DEFAULT_DEV_ADDR
) (
    input wire clk,
    input wire resetn,
    input wire scl,
    input wire sda,
    output reg sda_oe,
    output reg wr_strobe,
    output reg [7:0] wr_data,
    output reg [7:0] reg_ptr,
    input wire [7:0] rd_data
);

    // ------------------------------------------------------------------------
    // States
    // ------------------------------------------------------------------------
    localparam [3:0] S_IDLE = 4'h0;
    localparam [3:0] S_ADDR = 4'h1;
    localparam [3:0] S_AACK = 4'h2;
    localparam [3:0] S_REG = 4'h3;
    localparam [3:0] S_REGACK = 4'h4;
    localparam [3:0] S_WDATA = 4'h5;
    localparam [3:0] S_WACK = 4'h6;
    localparam [3:0] S_RDATA = 4'h7;
    localparam [3:0] S_RACK = 4'h8;

    reg scl_d;
    reg sda_d;
    reg [3:0] state;
    reg [3:0] cnt;
    reg [7:0] shift;
    reg rw;
    reg nack;

    wire scl_rise = scl & ~scl_d;
    wire scl_fall = ~scl & scl_d;
    wire start_cond = scl & scl_d & sda_d & ~sda;
    wire stop_cond = scl & scl_d & ~sda_d & sda;

    always @(posedge clk or negedge resetn) begin
        if (!resetn) begin
            scl_d <= 1'b1;
            sda_d <= 1'b1;
            state <= S_IDLE;
            cnt <= 4'h0;
            shift <= 8'h00;
            rw <= 1'b0;
            nack <= 1'b0;
            sda_oe <= 1'b0;
            wr_strobe <= 1'b0;
            wr_data <= 8'h00;
            reg_ptr <= 8'h00;
        end else begin
            scl_d <= scl;
            sda_d <= sda;
            wr_strobe <= 1'b0;
            if (start_cond) begin
                state <= S_ADDR;
                cnt <= 4'h0;
                sda_oe <= 1'b0;
            end else if (stop_cond) begin
                state <= S_IDLE;
                sda_oe <= 1'b0;
            end else if (scl_rise) begin
                case (state)
                    S_ADDR, S_REG, S_WDATA: begin
                        shift <= {shift[6:0], sda};
                        cnt <= cnt + 4'h1;
                    end
                    S_RDATA: cnt <= cnt + 4'h1;
                    S_RACK: nack <= sda;
                    default: ;
                endcase
            end else if (scl_fall) begin
                case (state)
                    S_ADDR: begin
                        if (cnt == `BYTE_BITS) begin
                            if (shift[7:1] == DEV_ADDR) begin
                                sda_oe <= 1'b1;
                                rw <= shift[0];
                                state <= S_AACK;
                            end else begin
                                state <= S_IDLE;
                            end
                        end
                    end
                    S_AACK: begin
                        cnt <= 4'h0;
                        if (rw) begin
                            shift <= rd_data;
                            reg_ptr <= reg_ptr + 8'h01;
                            sda_oe <= ~rd_data[7];
                            state <= S_RDATA;
                        end else begin
                            sda_oe <= 1'b0;
                            state <= S_REG;
                        end
                    end
                    S_REG: begin
                        if (cnt == `BYTE_BITS) begin
                            reg_ptr <= shift;
                            sda_oe <= 1'b1;
                            state <= S_REGACK;
                        end
                    end
                    S_REGACK: begin
                        sda_oe <= 1'b0;
                        cnt <= 4'h0;
                        state <= S_WDATA;
                    end
                    S_WDATA: begin
                        if (cnt == `BYTE_BITS) begin
                            wr_data <= shift;
                            wr_strobe <= 1'b1;
                            sda_oe <= 1'b1;
                            state <= S_WACK;
                        end
                    end
                    S_WACK: begin
                        sda_oe <= 1'b0;
                        reg_ptr <= reg_ptr + 8'h01;
                        cnt <= 4'h0;
                        state <= S_WDATA;
                    end
                    S_RDATA: begin
                        if (cnt == `BYTE_BITS) begin
                            sda_oe <= 1'b0;
                            state <= S_RACK;
                        end else begin
                            shift <= {shift[6:0], 1'b0};
                            sda_oe <= ~shift[6];
                        end
                    end
                    S_RACK: begin
                        cnt <= 4'h0;
                        if (nack) begin
                            state <= S_IDLE;
                        end else begin
                            shift <= rd_data;
                            reg_ptr <= reg_ptr + 8'h01;
                            sda_oe <= ~rd_data[7];
                            state <= S_RDATA;
                        end
                    end
                    default: state <= S_IDLE;
                endcase
            end
        end
    end

endmodule

// ### hdl/repeater_smbus_control_regs.v
// Control register slice of the repeater's serial slave register bank
//
// Behaviour
// - Control bit 7 set stops the automatic configuration load from EEPROM.
// - Control bit 3 enables slave register control when one, disables when zero.
// - Swing, de-emphasis and EQ settings apply only while register control enabled.
// - Writing one to reset bit 6 restores all registers, then self-clears.
// - Writing one to reset bit 5 restarts the EEPROM master machine, self-clears.
// - Threshold bit selects per-channel threshold when one, threshold pin when zero.
// - Idle override bit one lets per-channel idle controls force idle.
// - Per-channel idle select and auto act only while idle override is one.
`timescale 1ns/1ns
`include "repeater_regs_defines.vh"

module repeater_smbus_control_regs #(
    parameter [6:0] DEV_ADDR = `DEFAULT_DEV_ADDR,
    parameter NCH = 2,
    parameter SET_W = 8,
    parameter TH_W = 2
) (
    input wire clk,
    input wire resetn,
    input wire scl_pin,
    input wire sda_pin_in,
    output reg sda_pin_out,
    output wire sda_pin_oe,
    input wire eeprom_load_done,
    output reg eeprom_load_req,
    output reg eeprom_load_disable,
    output reg slave_reg_enable,
    output reg register_reset_pulse,
    output reg master_reset_pulse,
    output reg high_rate_mode,
    input wire [NCH*SET_W-1:0] output_swing_req,
    input wire [NCH*SET_W-1:0] output_deemphasis_req,
    input wire [NCH*SET_W-1:0] eq_boost_req,
    output reg [NCH*SET_W-1:0] output_swing,
    output reg [NCH*SET_W-1:0] output_deemphasis,
    output reg [NCH*SET_W-1:0] eq_boost,
    input wire [NCH*TH_W-1:0] ch_idle_threshold,
    input wire [TH_W-1:0] signal_detect_threshold_pin,
    output reg [NCH*TH_W-1:0] idle_threshold,
    input wire [NCH-1:0] ch_idle_auto,
    input wire [NCH-1:0] ch_idle_select,
    output reg [NCH-1:0] idle_force,
    output reg [NCH-1:0] idle_auto_detect
);

    // ------------------------------------------------------------------------
    // Pin synchronisers
    // ------------------------------------------------------------------------
    reg scl_s1;
    reg scl_s2;
    reg sda_s1;
    reg sda_s2;
    reg [TH_W-1:0] th_pin_s1;
    reg [TH_W-1:0] th_pin_s2;

    always @(posedge clk or negedge resetn) begin
        if (!resetn) begin
            scl_s1 <= 1'b1;
            scl_s2 <= 1'b1;
            sda_s1 <= 1'b1;
            sda_s2 <= 1'b1;
            th_pin_s1 <= {TH_W{1'b0}};
            th_pin_s2 <= {TH_W{1'b0}};
        end else begin
            scl_s1 <= scl_pin;
            scl_s2 <= scl_s1;
            sda_s1 <= sda_pin_in;
            sda_s2 <= sda_s1;
            th_pin_s1 <= signal_detect_threshold_pin;
            th_pin_s2 <= th_pin_s1;
        end
    end

    // ------------------------------------------------------------------------
    // Serial engine
    // ------------------------------------------------------------------------
    wire wr_strobe;
    wire [7:0] wr_data;
    wire [7:0] reg_ptr;
    wire [7:0] rd_data;

    smbus_byte_engine #(
        .DEV_ADDR(DEV_ADDR)
    ) u_engine (
        .clk(clk),
        .resetn(resetn),
        .scl(scl_s2),
        .sda(sda_s2),
        .sda_oe(sda_pin_oe),
        .wr_strobe(wr_strobe),
        .wr_data(wr_data),
        .reg_ptr(reg_ptr),
        .rd_data(rd_data)
    );

    // Open drain: only ever pulls low
    always @(posedge clk or negedge resetn) begin
        if (!resetn) begin
            sda_pin_out <= 1'b0;
        end else begin
            sda_pin_out <= 1'b0;
        end
    end

    // ------------------------------------------------------------------------
    // Register file
    // ------------------------------------------------------------------------
    reg [7:0] slave_control;
    reg [7:0] reset_and_control;
    reg [7:0] pin_override_select;

    function [7:0] reg_read;
        input [7:0] addr;
        input [7:0] r06;
        input [7:0] r07;
        input [7:0] r08;
        begin
            case (addr)
                `SLAVE_CONTROL_ADDR: reg_read = r06;
                `RESET_AND_CONTROL_ADDR: reg_read = r07;
                `PIN_OVERRIDE_SELECT_ADDR: reg_read = r08;
                default: reg_read = 8'h00;
            endcase
        end
    endfunction

    assign rd_data = reg_read(reg_ptr, slave_control, reset_and_control, pin_override_select);

    wire wr_rst = wr_strobe && (reg_ptr == `RESET_AND_CONTROL_ADDR);
    wire do_reg_reset = wr_rst && wr_data[`RESET_REGISTERS_BIT];
    wire do_master_reset = wr_rst && wr_data[`RESET_MASTER_BIT];

    always @(posedge clk or negedge resetn) begin
        if (!resetn) begin
            slave_control <= `SLAVE_CONTROL_RESET;
            reset_and_control <= `RESET_AND_CONTROL_RESET;
            pin_override_select <= `PIN_OVERRIDE_SELECT_RESET;
            register_reset_pulse <= 1'b0;
            master_reset_pulse <= 1'b0;
        end else begin
            register_reset_pulse <= do_reg_reset;
            master_reset_pulse <= do_master_reset;
            if (do_reg_reset) begin
                slave_control <= `SLAVE_CONTROL_RESET;
                reset_and_control <= `RESET_AND_CONTROL_RESET;
                pin_override_select <= `PIN_OVERRIDE_SELECT_RESET;
            end else if (wr_strobe) begin
                case (reg_ptr)
                    `SLAVE_CONTROL_ADDR: slave_control <= wr_data;
                    `RESET_AND_CONTROL_ADDR: begin
                        // Self-clearing bits never stored
                        reset_and_control <= wr_data & 8'h9f;
                    end
                    `PIN_OVERRIDE_SELECT_ADDR: pin_override_select <= wr_data;
                    default: ;
                endcase
            end
        end
    end

    // ------------------------------------------------------------------------
    // Control outputs
    // ------------------------------------------------------------------------
    always @(posedge clk or negedge resetn) begin
        if (!resetn) begin
            eeprom_load_disable <= 1'b0;
            slave_reg_enable <= 1'b0;
            high_rate_mode <= 1'b0;
            output_swing <= {NCH*SET_W{1'b0}};
            output_deemphasis <= {NCH*SET_W{1'b0}};
            eq_boost <= {NCH*SET_W{1'b0}};
        end else begin
            eeprom_load_disable <= slave_control[`EEPROM_CFG_DISABLE_BIT];
            slave_reg_enable <= slave_control[`REG_CONTROL_ENABLE_BIT];
            high_rate_mode <= pin_override_select[`HIGH_RATE_BIT];
            if (slave_control[`REG_CONTROL_ENABLE_BIT]) begin
                output_swing <= output_swing_req;
                output_deemphasis <= output_deemphasis_req;
                eq_boost <= eq_boost_req;
            end
        end
    end

    // ------------------------------------------------------------------------
    // Per-channel idle threshold and idle forcing
    // ------------------------------------------------------------------------
    wire thr_ovr = pin_override_select[`IDLE_THRESHOLD_OVR_BIT];
    wire idle_ovr = pin_override_select[`IDLE_FORCE_OVR_BIT];

    genvar ch;
    generate
        for (ch = 0; ch < NCH; ch = ch + 1) begin : g_ch
            always @(posedge clk or negedge resetn) begin
                if (!resetn) begin
                    idle_threshold[ch*TH_W +: TH_W] <= {TH_W{1'b0}};
                    idle_force[ch] <= 1'b0;
                    idle_auto_detect[ch] <= 1'b1;
                end else begin
                    idle_threshold[ch*TH_W +: TH_W] <= thr_ovr ?
                        ch_idle_threshold[ch*TH_W +: TH_W] : th_pin_s2;
                    idle_force[ch] <= idle_ovr & ch_idle_auto[ch] &
                        ch_idle_select[ch];
                    idle_auto_detect[ch] <= ~(idle_ovr & ch_idle_auto[ch]);
                end
            end
        end
    endgenerate

    // ------------------------------------------------------------------------
    // EEPROM master state machine
    // ------------------------------------------------------------------------
    localparam [1:0] M_WAIT = 2'h0;
    localparam [1:0] M_LOAD = 2'h1;
    localparam [1:0] M_DONE = 2'h2;

    reg [1:0] m_state;

    always @(posedge clk or negedge resetn) begin
        if (!resetn) begin
            m_state <= M_WAIT;
            eeprom_load_req <= 1'b0;
        end else if (master_reset_pulse) begin
            m_state <= M_WAIT;
            eeprom_load_req <= 1'b0;
        end else begin
            case (m_state)
                M_WAIT: begin
                    if (slave_control[`EEPROM_CFG_DISABLE_BIT]) begin
                        m_state <= M_DONE;
                    end else begin
                        m_state <= M_LOAD;
                        eeprom_load_req <= 1'b1;
                    end
                end
                M_LOAD: begin
                    if (eeprom_load_done) begin
                        m_state <= M_DONE;
                        eeprom_load_req <= 1'b0;
                    end
                end
                M_DONE: eeprom_load_req <= 1'b0;
                default: begin
                    m_state <= M_WAIT;
                    eeprom_load_req <= 1'b0;
                end
            endcase
        end
    end

endmodule

// ### test/smbus_host_model.sv
// Serial host model: drives the clock and pulls the open-drain data line
`timescale 1ns/1ns
module smbus_host_model #(
    parameter HALF = 10
) (
    input wire clk,
    input wire sda,
    output logic scl,
    output logic sda_low
);
    initial begin
        scl = 1'b1;
        sda_low = 1'b0;
    end
    // Data moves while the clock is low, except in start and stop, which move it while the clock is high
    task automatic start_cond();
        sda_low = 1'b0;
        repeat (HALF) @(negedge clk);
        scl = 1'b1;
        repeat (HALF) @(negedge clk);
        sda_low = 1'b1;
        repeat (HALF) @(negedge clk);
        scl = 1'b0;
    endtask
    task automatic stop_cond();
        sda_low = 1'b1;
        repeat (HALF) @(negedge clk);
        scl = 1'b1;
        repeat (HALF) @(negedge clk);
        sda_low = 1'b0;
        repeat (HALF) @(negedge clk);
    endtask
    task automatic bit_xfer(input logic b, output logic s);
        sda_low = ~b;
        repeat (HALF) @(negedge clk);
        scl = 1'b1;
        repeat (HALF / 2) @(negedge clk);
        s = sda;
        repeat (HALF - HALF / 2) @(negedge clk);
        scl = 1'b0;
    endtask
    task automatic put_byte(input logic [7:0] d, output logic ack);
        logic s;
        for (int i = 7; i >= 0; i--) bit_xfer(d[i], s);
        bit_xfer(1'b1, ack);
    endtask
    task automatic get_byte(input logic nack, output logic [7:0] d);
        logic s;
        for (int i = 7; i >= 0; i--) begin
            bit_xfer(1'b1, s);
            d[i] = s;
        end
        bit_xfer(nack, s);
    endtask
endmodule

// ### test/repeater_smbus_control_regs_chk.sv
// Port checks for the control register slice
`timescale 1ns/1ns
module repeater_smbus_control_regs_chk #(
    parameter NCH = 2,
    parameter SET_W = 8
) (
    input wire clk,
    input wire resetn,
    input wire eeprom_load_done,
    input wire eeprom_load_req,
    input wire eeprom_load_disable,
    input wire slave_reg_enable,
    input wire register_reset_pulse,
    input wire master_reset_pulse,
    input wire high_rate_mode,
    input wire [NCH*SET_W-1:0] output_swing_req,
    input wire [NCH*SET_W-1:0] output_swing,
    input wire [NCH*SET_W-1:0] eq_boost,
    input wire [NCH-1:0] ch_idle_auto,
    input wire [NCH-1:0] ch_idle_select,
    input wire [NCH-1:0] idle_force,
    input wire [NCH-1:0] idle_auto_detect
);
    default clocking cb @(posedge clk); endclocking
    default disable iff (!resetn);
    chk_swing_follows: assert property (
        slave_reg_enable |-> output_swing == $past(output_swing_req))
        else $error("swing not following request");
    chk_settings_hold: assert property (
        !slave_reg_enable |-> $stable(output_swing) && $stable(eq_boost))
        else $error("settings moved while disabled");
    chk_force_source: assert property (
        idle_force == (~idle_auto_detect & $past(ch_idle_select)))
        else $error("idle force not from select");
    chk_auto_needs_bit: assert property (
        (~idle_auto_detect & ~$past(ch_idle_auto)) == '0)
        else $error("auto detect left without auto bit");
    chk_regreset_single: assert property (
        register_reset_pulse |=> !register_reset_pulse)
        else $error("register reset pulse too long");
    chk_regreset_clears: assert property (
        register_reset_pulse |-> ##[0:2]
        (!slave_reg_enable && !eeprom_load_disable && !high_rate_mode))
        else $error("register reset left bits set");
    chk_master_single: assert property (
        master_reset_pulse |=> !master_reset_pulse)
        else $error("master reset pulse too long");
    chk_load_blocked: assert property (
        master_reset_pulse && eeprom_load_disable |-> ##2 !eeprom_load_req [*8])
        else $error("load started while disabled");
    chk_load_restarts: assert property (
        master_reset_pulse && !eeprom_load_disable |-> ##[1:6] eeprom_load_req)
        else $error("load not restarted");
    chk_load_ends: assert property (
        eeprom_load_req && eeprom_load_done |=> !eeprom_load_req)
        else $error("load request outlived done");
    cover property (register_reset_pulse);
    cover property (master_reset_pulse && eeprom_load_disable);
    cover property (idle_force != '0);
endmodule
bind repeater_smbus_control_regs repeater_smbus_control_regs_chk #(.NCH(NCH), .SET_W(SET_W))
    chk_i (.clk(clk), .resetn(resetn), .eeprom_load_done(eeprom_load_done),
    .eeprom_load_req(eeprom_load_req), .eeprom_load_disable(eeprom_load_disable),
    .slave_reg_enable(slave_reg_enable), .register_reset_pulse(register_reset_pulse),
    .master_reset_pulse(master_reset_pulse), .high_rate_mode(high_rate_mode),
    .output_swing_req(output_swing_req), .output_swing(output_swing), .eq_boost(eq_boost),
    .ch_idle_auto(ch_idle_auto), .ch_idle_select(ch_idle_select), .idle_force(idle_force),
    .idle_auto_detect(idle_auto_detect));

// ### test/repeater_smbus_control_regs_tb.sv
// Self-checking bench for the control register slice
`timescale 1ns/1ns
`include "repeater_regs_defines.vh"
module repeater_smbus_control_regs_tb;
    localparam W = 16;
    logic clk = 1'b0;
    logic resetn = 1'b0;
    logic eeprom_load_done = 1'b0;
    logic scl, sda_low, sda_pin_out, sda_pin_oe, load_req, load_dis, reg_en, hi_rate, rr_p, mr_p;
    logic [W-1:0] sw_req = '0, de_req = '0, eq_req = '0, sw, de, eq;
    logic [W-1:0] e_sw = '0, e_de = '0, e_eq = '0;
    logic [3:0] ch_th = '0, th;
    logic [1:0] pin_th = '0, auto = '0, sel = '0, force_o, auto_det;
    logic [7:0] m [6:8];
    int errors = 0, tests_run = 0, rr_cnt = 0, mr_cnt = 0, seed;
    wire sda = sda_low ? 1'b0 : (sda_pin_oe ? sda_pin_out : 1'b1);
    always #2 clk = ~clk;
    always @(posedge clk) begin
        rr_cnt <= rr_cnt + int'(rr_p === 1'b1);
        mr_cnt <= mr_cnt + int'(mr_p === 1'b1);
    end
    smbus_host_model smbus_host_model_i (.clk(clk), .sda(sda), .scl(scl), .sda_low(sda_low));
    repeater_smbus_control_regs repeater_smbus_control_regs_i (.clk(clk), .resetn(resetn),
        .scl_pin(scl), .sda_pin_in(sda), .sda_pin_out(sda_pin_out), .sda_pin_oe(sda_pin_oe),
        .eeprom_load_done(eeprom_load_done), .eeprom_load_req(load_req),
        .eeprom_load_disable(load_dis), .slave_reg_enable(reg_en), .register_reset_pulse(rr_p),
        .master_reset_pulse(mr_p), .high_rate_mode(hi_rate), .output_swing_req(sw_req),
        .output_deemphasis_req(de_req), .eq_boost_req(eq_req), .output_swing(sw),
        .output_deemphasis(de), .eq_boost(eq), .ch_idle_threshold(ch_th),
        .signal_detect_threshold_pin(pin_th), .idle_threshold(th), .ch_idle_auto(auto),
        .ch_idle_select(sel), .idle_force(force_o), .idle_auto_detect(auto_det));
    // ------------------------------------------------------------------
    // Compare, bus and wait tasks
    // ------------------------------------------------------------------
    task automatic cmp_reg(input string n, input logic [7:0] e, input logic [7:0] g);
        tests_run++;
        if (g !== e) begin
            errors++;
            $display("mismatch %s expected %h seen %h", n, e, g);
        end
    endtask
    task automatic cmp_out(input string n, input logic [W-1:0] e, input logic [W-1:0] g);
        tests_run++;
        if (g !== e) begin
            errors++;
            $display("mismatch %s expected %h seen %h", n, e, g);
        end
    endtask
    task automatic summarize();
        $display("comparisons %0d mismatches %0d", tests_run, errors);
        if (errors == 0 && tests_run > 0) $display("Regression OK");
        else $display("Regression broken");
        $finish;
    endtask
    task automatic reg_wr(input logic [7:0] a, input logic [7:0] d);
        logic ack;
        smbus_host_model_i.start_cond();
        smbus_host_model_i.put_byte({`DEFAULT_DEV_ADDR, 1'b0}, ack);
        cmp_out("addr_ack", '0, W'(ack));
        smbus_host_model_i.put_byte(a, ack);
        smbus_host_model_i.put_byte(d, ack);
        smbus_host_model_i.stop_cond();
        if (a == 8'h07 && d[6]) begin
            m[6] = 8'h10;
            m[7] = 8'h01;
            m[8] = 8'h00;
        end else if (a >= 8'h06 && a <= 8'h08) m[a] = (a == 8'h07) ? (d & 8'h9f) : d;
    endtask
    task automatic reg_rd(input logic [7:0] a, input int n = 1);
        logic ack;
        logic [7:0] d;
        smbus_host_model_i.start_cond();
        smbus_host_model_i.put_byte({`DEFAULT_DEV_ADDR, 1'b0}, ack);
        smbus_host_model_i.put_byte(a, ack);
        smbus_host_model_i.start_cond();
        smbus_host_model_i.put_byte({`DEFAULT_DEV_ADDR, 1'b1}, ack);
        cmp_out("rd_addr_ack", '0, W'(ack));
        for (int i = 0; i < n; i++) begin
            smbus_host_model_i.get_byte(i == n - 1, d);
            cmp_reg("read", (a + i >= 6 && a + i <= 8) ? m[a + i] : 8'h00, d);
        end
        smbus_host_model_i.stop_cond();
    endtask
    task automatic wait_req(input logic v);
        int n;
        n = 0;
        while (load_req !== v && n < 100) begin
            @(negedge clk);
            n++;
        end
        cmp_out("load_req", W'(v), W'(load_req));
        if (n == 100) summarize();
    endtask
    task automatic load_cycle();
        wait_req(1'b1);
        eeprom_load_done = 1'b1;
        @(negedge clk);
        eeprom_load_done = 1'b0;
        wait_req(1'b0);
    endtask
    task automatic ctl_chk();
        cmp_out("load_disable", W'(m[6][7]), W'(load_dis));
        cmp_out("reg_enable", W'(m[6][3]), W'(reg_en));
        cmp_out("high_rate", W'(m[8][3]), W'(hi_rate));
    endtask
    // ------------------------------------------------------------------
    // Main sequence
    // ------------------------------------------------------------------
    initial begin
        logic [1:0] e_f, e_a;
        logic [3:0] e_th;
        int e;
        m[6] = 8'h10;
        m[7] = 8'h01;
        m[8] = 8'h00;
        seed = $urandom(74);
        repeat (3) @(negedge clk);
        resetn = 1'b1;
        load_cycle();
        for (int a = 5; a <= 8; a++) reg_rd(a[7:0]);
        $display("test defaults done");
        repeat (4) begin
            reg_wr(8'h06, 8'($urandom));
            reg_wr(8'h08, 8'($urandom));
            reg_rd(8'h06);
            reg_rd(8'h08);
            ctl_chk();
        end
        reg_wr(8'h05, 8'($urandom));
        reg_rd(8'h05);
        $display("test random access done");
        for (int k = 0; k < 4; k++) begin
            reg_wr(8'h06, {4'h1, k[0], 3'h0});
            sw_req = W'($urandom);
            de_req = W'($urandom);
            eq_req = W'($urandom);
            repeat (4) @(negedge clk);
            if (k[0]) begin
                e_sw = sw_req;
                e_de = de_req;
                e_eq = eq_req;
            end
            cmp_out("swing", e_sw, sw);
            cmp_out("deemphasis", e_de, de);
            cmp_out("eq", e_eq, eq);
        end
        $display("test setting gate done");
        for (int k = 0; k < 4; k++) begin
            reg_wr(8'h08, {1'b0, k[1], 1'b0, k[0], 4'h8});
            ch_th = 4'($urandom);
            pin_th = 2'($urandom);
            auto = 2'($urandom);
            sel = 2'($urandom);
            repeat (5) @(negedge clk);
            e_th = k[1] ? ch_th : {pin_th, pin_th};
            e_f = k[0] ? (auto & sel) : 2'b00;
            e_a = k[0] ? ~auto : 2'b11;
            cmp_out("threshold", W'(e_th), W'(th));
            cmp_out("idle_force", W'(e_f), W'(force_o));
            cmp_out("auto_detect", W'(e_a), W'(auto_det));
        end
        $display("test idle override done");
        reg_wr(8'h06, 8'h90);
        e = mr_cnt;
        reg_wr(8'h07, 8'h21);
        repeat (10) @(negedge clk);
        cmp_out("master_pulses", W'(e + 1), W'(mr_cnt));
        cmp_out("load_req", '0, W'(load_req));
        reg_rd(8'h07);
        reg_wr(8'h06, 8'h10);
        reg_wr(8'h07, 8'h21);
        load_cycle();
        $display("test master reset done");
        reg_wr(8'h06, 8'h9b);
        reg_wr(8'h08, 8'h5c);
        e = rr_cnt;
        reg_wr(8'h07, 8'h41);
        cmp_out("reg_pulses", W'(e + 1), W'(rr_cnt));
        reg_rd(8'h06, 3);
        ctl_chk();
        $display("test register reset done");
        summarize();
    end
endmodule
